// ---- aol_pkg.sv ----
// constants shared by both ends of the addressable output latch link
// assumes one 10 MHz core clock on both ends
package aol_pkg;
  // bus word layout
  localparam int WORD_W = 8;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 3;
  localparam int VALUE_BIT = 3;
  localparam int DIGIT_LSB = 4;
  localparam int DIGIT_W = 4;
  localparam int NUM_OUT = 8;
  localparam int SEG_W = 7;
  localparam logic VALUE_ON = 1'b1;
  localparam logic LATCH_OFF = 1'b0;
  // host register byte offsets
  localparam logic [31:0] CMD_OFF = 32'h0000_0000;
  localparam logic [31:0] CTRL_OFF = 32'h0000_0004;
  localparam logic [31:0] STAT_OFF = 32'h0000_0008;
  // command register fields
  localparam int CMD_SEG_BIT = 8;
  // control register fields
  localparam int CTRL_CLR_BIT = 0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CLR_BIT = 1;
  localparam int STAT_WORD_LSB = 8;
  localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
  localparam logic [SEG_W-1:0] SEG_RST = 7'h00;
  // host bus cycle states
  typedef enum logic [2:0] {
    AOL_IDLE = 3'b001,
    AOL_SETUP = 3'b010,
    AOL_ACT = 3'b100
  } aol_state_t;
endpackage : aol_pkg

// ---- aol_bus_if.sv ----
// latch bus between the host controller and the output latch device
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface aol_bus_if;
  logic [7:0] bus_word; // location, value and digit
  logic chip_sel_n; // low: write the addressed latch
  logic segment_latch_strobe_n; // low: digit latch follows word
  logic all_outputs_reset_n; // low: every output latch off; digit latch keeps its value

  modport dev (
    input bus_word,
    input chip_sel_n,
    input segment_latch_strobe_n,
    input all_outputs_reset_n
  );

  modport hst (
    output bus_word,
    output chip_sel_n,
    output segment_latch_strobe_n,
    output all_outputs_reset_n
  );
endinterface : aol_bus_if

// ---- aol_host.sv ----
// host end: APB slave registers that drive latch bus cycles
// assumes APB master on core_clk; device samples on the same clock
`timescale 1ns/1ps
module aol_host
  import aol_pkg::*;
(
  input wire logic core_clk, // 10 MHz core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  aol_bus_if.hst bus // latch bus
);
  aol_state_t state_reg;
  aol_state_t state_next;
  logic [WORD_W-1:0] word_reg;
  logic seg_reg;
  logic cs_n_reg;
  logic strobe_n_reg;
  logic clr_reg;
  logic busy;
  logic hit_cmd;
  logic hit_ctrl;
  logic hit_stat;
  logic access;
  logic cmd_go;
  logic [31:0] rd_mux;

  assign busy = (state_reg != AOL_IDLE);
  assign hit_cmd = (paddr == CMD_OFF);
  assign hit_ctrl = (paddr == CTRL_OFF);
  assign hit_stat = (paddr == STAT_OFF);
  assign access = psel & penable;
  // command write stalls while a bus cycle is running
  assign pready = ~(hit_cmd & pwrite & busy);
  assign pslverr = ~(hit_cmd | hit_ctrl | hit_stat);
  assign cmd_go = access & pready & pwrite & hit_cmd;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_stat) begin
      rd_mux[STAT_BUSY_BIT] = busy;
      rd_mux[STAT_CLR_BIT] = clr_reg;
      rd_mux[STAT_WORD_LSB +: WORD_W] = word_reg;
    end else if (hit_ctrl) begin
      rd_mux[CTRL_CLR_BIT] = clr_reg;
    end else if (hit_cmd) begin
      rd_mux[0 +: WORD_W] = word_reg;
      rd_mux[CMD_SEG_BIT] = seg_reg;
    end
  end

  // read word captured in setup, stands through access
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      word_reg <= WORD_RST;
      seg_reg <= 1'b0;
    end else if (cmd_go) begin
      word_reg <= pwdata[0 +: WORD_W];
      seg_reg <= pwdata[CMD_SEG_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clr_reg <= CTRL_RST[CTRL_CLR_BIT];
    end else if (access & pwrite & hit_ctrl) begin
      clr_reg <= pwdata[CTRL_CLR_BIT];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AOL_IDLE: begin
        if (cmd_go) begin
          state_next = AOL_SETUP;
        end
      end
      AOL_SETUP: state_next = AOL_ACT;
      AOL_ACT: state_next = AOL_IDLE;
      default: state_next = AOL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= AOL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_n_reg <= 1'b1;
      strobe_n_reg <= 1'b1;
    end else begin
      cs_n_reg <= ~(state_next == AOL_ACT);
      strobe_n_reg <= ~((state_next == AOL_ACT) & seg_reg);
    end
  end

  assign bus.bus_word = word_reg;
  assign bus.chip_sel_n = cs_n_reg;
  assign bus.segment_latch_strobe_n = strobe_n_reg;
  assign bus.all_outputs_reset_n = ~clr_reg;
endmodule : aol_host

// ---- aol_device.sv ----
// device end: eight addressable output latches and a digit decoder
// assumes latch bus signals come from logic on the same core clock
`timescale 1ns/1ps
module aol_device
  import aol_pkg::*;
(
  input wire logic core_clk, // 10 MHz core clock
  input wire logic rst_n, // synchronous reset, active low
  aol_bus_if.dev bus, // latch bus from the host
  output logic [NUM_OUT-1:0] drive_out, // sink pin level
  output logic [NUM_OUT-1:0] drive_oe, // high: pin driven
  output logic [NUM_OUT-1:0] latch_state, // 1: output on
  output logic [DIGIT_W-1:0] digit_code, // latched digit
  output logic [SEG_W-1:0] segment_out // segments a..g, bit 0 = a
);
  localparam int NUM_GLYPH = 1 << DIGIT_W;
  logic [NUM_OUT-1:0] latch_reg;
  logic [NUM_OUT-1:0] latch_next;
  logic [NUM_OUT-1:0] select_hot;
  logic [NUM_OUT-1:0] set_hot;
  logic [NUM_OUT-1:0] reset_hot;
  logic [ADDR_W-1:0] write_addr;
  logic write_value;
  logic write_en;
  logic clear_all;
  logic digit_take;
  logic [DIGIT_W-1:0] digit_reg;
  logic [DIGIT_W-1:0] digit_next;
  logic [SEG_W-1:0] seg_reg;
  logic [SEG_W-1:0] seg_next;
  logic [SEG_W-1:0] glyph_rom [NUM_GLYPH];

  function automatic logic [SEG_W-1:0] aol_glyph(
    input logic [DIGIT_W-1:0] code
  );
    logic [SEG_W-1:0] pat;
    pat = SEG_RST;
    case (code)
      4'h0: pat = 7'h3f;
      4'h1: pat = 7'h06;
      4'h2: pat = 7'h5b;
      4'h3: pat = 7'h4f;
      4'h4: pat = 7'h66;
      4'h5: pat = 7'h6d;
      4'h6: pat = 7'h7d;
      4'h7: pat = 7'h07;
      4'h8: pat = 7'h7f;
      4'h9: pat = 7'h6f;
      4'ha: pat = 7'h77;
      4'hb: pat = 7'h7c;
      4'hc: pat = 7'h39;
      4'hd: pat = 7'h5e;
      4'he: pat = 7'h79;
      4'hf: pat = 7'h71;
      default: pat = SEG_RST;
    endcase
    return pat;
  endfunction : aol_glyph

  // fixed table, one row per code
  genvar ri;
  generate
    for (ri = 0; ri < NUM_GLYPH; ri = ri + 1) begin : g_rom
      assign glyph_rom[ri] = aol_glyph(DIGIT_W'(ri));
    end
  endgenerate

  assign write_addr = bus.bus_word[ADDR_LSB +: ADDR_W];
  assign write_value = (bus.bus_word[VALUE_BIT] == VALUE_ON);

  assign write_en = ~bus.chip_sel_n;

  // host keeps this high when unused
  assign clear_all = ~bus.all_outputs_reset_n;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_out
      assign select_hot[gi] = write_en &
        (write_addr == ADDR_W'(gi));

      // value bit chooses set or reset
      assign set_hot[gi] = select_hot[gi] & write_value;
      assign reset_hot[gi] = select_hot[gi] & ~write_value;

      always_comb begin
        latch_next[gi] = latch_reg[gi];
        if (clear_all) begin
          latch_next[gi] = LATCH_OFF;
        end else if (set_hot[gi]) begin
          latch_next[gi] = ~LATCH_OFF;
        end else if (reset_hot[gi]) begin
          latch_next[gi] = LATCH_OFF;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          latch_reg[gi] <= LATCH_OFF;
        end else begin
          latch_reg[gi] <= latch_next[gi];
        end
      end

      assign drive_out[gi] = 1'b0;
      assign drive_oe[gi] = latch_reg[gi];
    end
  endgenerate

  assign latch_state = latch_reg;

  assign digit_take = ~bus.segment_latch_strobe_n;

  always_comb begin
    digit_next = digit_reg;
    if (digit_take) begin
      digit_next = bus.bus_word[DIGIT_LSB +: DIGIT_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      digit_reg <= '0;
    end else begin
      digit_reg <= digit_next;
    end
  end

  assign seg_next = glyph_rom[digit_reg];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seg_reg <= SEG_RST;
    end else begin
      seg_reg <= seg_next;
    end
  end

  assign digit_code = digit_reg;
  assign segment_out = seg_reg;
endmodule : aol_device

// ---- aol_bus_properties.sv ----
// assertions on the latch bus and the device outputs
// assumes one clock; inputs mirror bus and device ports
`timescale 1ns/1ps
module aol_bus_properties
  import aol_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // sync reset
  input wire logic [7:0] bus_word, // bus word
  input wire logic chip_sel_n, // write select
  input wire logic segment_latch_strobe_n, // digit strobe
  input wire logic all_outputs_reset_n, // master clear
  input wire logic [NUM_OUT-1:0] latch_state, // latches
  input wire logic [NUM_OUT-1:0] drive_oe, // sink enables
  input wire logic [NUM_OUT-1:0] drive_out, // sink levels
  input wire logic [DIGIT_W-1:0] digit_code, // digit
  input wire logic [SEG_W-1:0] segment_out // segments
);
  localparam logic [6:0] GL[16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
    7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c,
    7'h39, 7'h5e, 7'h79, 7'h71};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cmd;
    !chip_sel_n ##1 chip_sel_n;
  endsequence
  sequence s_wr;
    !chip_sel_n && all_outputs_reset_n;
  endsequence
  AST_SET: assert property (s_wr ##0 bus_word[3] |=>
    latch_state[$past(bus_word[2:0])]) else $error("set lost");
  AST_OFF: assert property (s_wr ##0 !bus_word[3] |=>
    !latch_state[$past(bus_word[2:0])] && ((latch_state ^
    $past(latch_state)) & ~(8'h01 << $past(bus_word[2:0]))) == 8'h00)
    else $error("off write disturbed");
  AST_HOLD: assert property (chip_sel_n && all_outputs_reset_n
    |=> $stable(latch_state)) else $error("latch moved");
  AST_CLR: assert property (!all_outputs_reset_n |=>
    latch_state == 8'h00) else $error("clear missed");
  AST_SINK: assert property (drive_oe == latch_state &&
    (drive_oe & drive_out) == 8'h00) else $error("sink mismatch");
  AST_DIG: assert property (!segment_latch_strobe_n |=>
    digit_code == $past(bus_word[7:4])) else $error("digit lost");
  AST_SEG: assert property (!segment_latch_strobe_n |-> ##2
    segment_out == GL[$past(bus_word[7:4], 2)]) else $error("glyph");
  AST_PULSE: assert property ($fell(chip_sel_n) |-> s_cmd)
    else $error("select too long");
  AST_PAIR: assert property (!segment_latch_strobe_n |->
    !chip_sel_n) else $error("strobe alone");
endmodule : aol_bus_properties

// ---- addressable_output_latch_tb.sv ----
// self-checking bench: host and device joined by the latch bus
// assumes a 10 MHz core clock; APB driven by the tasks below
`timescale 1ns/1ps
module addressable_output_latch_tb
  import aol_pkg::*;
;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] latch_state, drive_oe, drive_out, lat;
  logic [3:0] digit_code, dig;
  logic [6:0] segment_out;
  logic er, clr;
  logic [8:0] v;
  int n_errors, n_checks, seed, i;
  localparam logic [6:0] GL[16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
    7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c,
    7'h39, 7'h5e, 7'h79, 7'h71};
  aol_bus_if bus_if();
  aol_host u_aol_host(.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
  aol_device u_aol_device(.core_clk(core_clk), .rst_n(rst_n),
    .bus(bus_if), .drive_out(drive_out), .drive_oe(drive_oe),
    .latch_state(latch_state), .digit_code(digit_code),
    .segment_out(segment_out));
  aol_bus_properties u_aol_bus_properties(.core_clk(core_clk),
    .rst_n(rst_n), .bus_word(bus_if.bus_word),
    .chip_sel_n(bus_if.chip_sel_n),
    .segment_latch_strobe_n(bus_if.segment_latch_strobe_n),
    .all_outputs_reset_n(bus_if.all_outputs_reset_n),
    .latch_state(latch_state), .drive_oe(drive_oe),
    .drive_out(drive_out),
    .digit_code(digit_code), .segment_out(segment_out));
  always #50 core_clk = ~core_clk;
  task stop_test;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cmd(input logic [8:0] c);
    apb(1'b1, CMD_OFF, 32'(c));
    repeat (5) @(posedge core_clk);
    if (!clr) lat[c[2:0]] = c[3];
    if (c[8]) dig = c[7:4];
    chk("latch", 32'(lat), 32'(latch_state));
    chk("sink", 32'(lat), 32'(drive_oe));
    chk("pin", 32'h0, 32'(drive_out & drive_oe));
    chk("digit", 32'(dig), 32'(digit_code));
    chk("seg", 32'(GL[dig]), 32'(segment_out));
  endtask : cmd
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    stop_test;
  end
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    seed = 32'ha75c;
    lat = 8'h00;
    dig = 4'h0;
    clr = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("seg0", 32'(GL[0]), 32'(segment_out));
    for (i = 0; i < 16; i++) cmd({1'b1, 4'(i), 1'b1, 3'(i)});
    for (i = 0; i < 40; i++) cmd(9'($random(seed)));
    v = 9'($random(seed));
    cmd(v);
    apb(1'b0, CMD_OFF, 32'h0);
    chk("cmd rd", 32'(v), rd);
    apb(1'b1, CTRL_OFF, 32'h1);
    clr = 1'b1;
    lat = 8'h00;
    cmd(9'($random(seed)) & 9'h0ff);
    apb(1'b0, STAT_OFF, 32'h0);
    chk("clr st", 32'h1, 32'(rd[STAT_CLR_BIT]));
    apb(1'b1, CTRL_OFF, 32'h0);
    clr = 1'b0;
    for (i = 0; i < 8; i++) cmd({5'h00, 1'b1, 3'(i)});
    cmd(9'h003);
    apb(1'b0, 32'h0000_0010, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    chk("rd0", 32'h0, rd);
    stop_test;
  end
endmodule : addressable_output_latch_tb
